// ==== iirp_defs.svh ====
`ifndef IIRP_DEFS_SVH
`define IIRP_DEFS_SVH
// direct offsets on the isa side
`define IIRP_OFS_STATUS   2'h0
`define IIRP_OFS_INDEX    2'h1
`define IIRP_OFS_DLOW     2'h2
`define IIRP_OFS_DHIGH    2'h3
// indirect indices
`define IIRP_IX_FIFO      8'h0B
`define IIRP_IX_PAIRSEL   8'h4E
`define IIRP_IX_CHIPCTL   8'h80
`define IIRP_IX_IRQEN     8'h81
`define IIRP_IX_RSVD82    8'h82
`define IIRP_IX_IRQSTAT   8'h83
`define IIRP_IX_RATE_LO   8'h84
`define IIRP_IX_RATE_HI   8'h85
`define IIRP_IX_RATE_CTL  8'h86
// field positions
`define IIRP_BIT_IRQ      7
`define IIRP_BIT_BUSY     6
`define IIRP_BIT_MIE      7
`define IIRP_BIT_PAIRED   0
`define IIRP_RATE_HI_W    4
// fifo depth in words
`define IIRP_FIFO_DEPTH   16
`define IIRP_FIFO_AW      4
// host-side software port offsets
`define IIRP_SW_ADDR      2'h0
`define IIRP_SW_WDATA     2'h1
`define IIRP_SW_CTRL      2'h2
`define IIRP_SW_RESULT    2'h3
`define IIRP_CTL_START    0
`define IIRP_CTL_READ     1
`define IIRP_CTL_WIDE     2
`define IIRP_CTL_SPLIT    3
`define IIRP_CTL_DIRECT   5
// host bus phase points, in clocks from the start of a phase
`define IIRP_PH_STB_ON    4'h1
`define IIRP_PH_STB_OFF   4'hA
`define IIRP_PH_CS_OFF    4'hC
`define IIRP_PH_SAMPLE    4'hD
`define IIRP_PH_LAST      4'hF
`endif

// ==== iirp_pkg.sv ====
`default_nettype none
package iirp_pkg;
    typedef logic [7:0]  iirp_byte_t;
    typedef logic [15:0] iirp_word_t;
    typedef logic [1:0]  iirp_ofs_t;
    typedef enum logic [4:0] {
        IIRP_IDLE   = 5'h01,
        IIRP_SETIX  = 5'h02,
        IIRP_DLOW   = 5'h04,
        IIRP_DHIGH  = 5'h08,
        IIRP_DONE   = 5'h10
    } iirp_state_t;
endpackage
`default_nettype wire

// ==== iirp_bus_if.sv ====
`default_nettype none
// isa-style io bus between the host end and the device end
interface iirp_bus_if;
    logic        cs_n;
    logic        ior_n;
    logic        iow_n;
    logic        sbhe_n;
    logic [1:0]  addr;
    logic [15:0] host_data;
    logic [15:0] dev_data;
    logic        dev_data_oe_n;
    logic        irq;
    modport host (output cs_n, ior_n, iow_n, sbhe_n, addr, host_data,
                  input dev_data, dev_data_oe_n, irq);
    modport dev  (input cs_n, ior_n, iow_n, sbhe_n, addr, host_data,
                  output dev_data, dev_data_oe_n, irq);
endinterface
`default_nettype wire

// ==== iirp_pin_sync.sv ====
`include "iirp_defs.svh"
`default_nettype none
// three-stage synchroniser; a change counts when stages two and three agree
module iirp_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clock,
    input  wire logic         nrst,
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s1_q  <= INIT;
            s2_q  <= INIT;
            s3_q  <= INIT;
            level <= INIT;
        end else begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < W; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level[i] <= s3_q[i];
                end
            end
        end
    end
endmodule // iirp_pin_sync
`default_nettype wire

// ==== iirp_device.sv ====
// The implementer's own choice: the address-and-strobe port.
`include "iirp_defs.svh"
`default_nettype none
module iirp_device (
    input  wire logic                clock,
    input  wire logic                nrst,
    iirp_bus_if.dev                  bus,
    input  wire logic [5:0]          irq_events,
    input  wire logic                play_fifo_pop,
    output logic                     play_fifo_full,
    output iirp_pkg::iirp_word_t     play_fifo_head,
    output logic                     play_fifo_empty,
    output iirp_pkg::iirp_byte_t     chip_control,
    output logic [11:0]              sample_rate,
    output iirp_pkg::iirp_byte_t     rate_control
);
    import iirp_pkg::*;

    logic        cs_s, rd_s, wr_s, bhe_s;
    logic [1:0]  addr_s;
    logic [15:0] wd_s;
    logic        rd_p_q, wr_p_q;
    iirp_byte_t  index_q, clear_q, pending_q, irqen_q, pairsel_q;
    iirp_byte_t  chipctl_q, rate_lo_q, ratectl_q;
    logic [3:0]  rate_hi_q;
    iirp_byte_t  split_lo_q;
    logic        oe_n_q, irq_q;
    iirp_word_t  fifo_mem [`IIRP_FIFO_DEPTH];
    logic [`IIRP_FIFO_AW:0] wp_q, rp_q;

    // select and strobe pins inverted so their stages idle at zero; no false strobe edge after reset
    iirp_pin_sync #(.W(22), .INIT(22'h0)) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .pin   ({~bus.cs_n, ~bus.ior_n, ~bus.iow_n, ~bus.sbhe_n, bus.addr, bus.host_data}),
        .level ({cs_s, rd_s, wr_s, bhe_s, addr_s, wd_s})
    );

    // strobe edges, taken only under select
    wire rd_go = rd_s & ~rd_p_q & cs_s;
    wire wr_go = wr_s & ~wr_p_q & cs_s;
    wire paired = pairsel_q[`IIRP_BIT_PAIRED];
    wire master_interrupt_enable    = irqen_q[`IIRP_BIT_MIE];
    wire at_st  = addr_s == `IIRP_OFS_STATUS;
    wire at_ix  = addr_s == `IIRP_OFS_INDEX;
    wire at_lo  = addr_s == `IIRP_OFS_DLOW;
    wire at_hi  = addr_s == `IIRP_OFS_DHIGH;
    wire is_fifo = index_q == `IIRP_IX_FIFO;
    wire fifo_full  = (wp_q[`IIRP_FIFO_AW] != rp_q[`IIRP_FIFO_AW]) &&
                      (wp_q[`IIRP_FIFO_AW-1:0] == rp_q[`IIRP_FIFO_AW-1:0]);
    wire fifo_empty = wp_q == rp_q;
    // sources held off while their clear bit stands
    wire [5:0] live = pending_q[5:0] & irqen_q[5:0] & ~clear_q[5:0];
    wire irq_d = master_interrupt_enable & |live;
    wire [7:0] status = {irq_q, ~fifo_full, pending_q[5:0] & ~clear_q[5:0]};
    wire word_wr = wr_go & at_lo & bhe_s & is_fifo;
    wire split_wr = wr_go & at_hi & is_fifo;
    wire push = (word_wr | split_wr) & ~fifo_full;
    wire [15:0] push_word = word_wr ? wd_s : {wd_s[7:0], split_lo_q};

    // write decode, one target per wire
    wire wr_clear = wr_go & at_st;
    wire wr_index = wr_go & at_ix;
    wire wr_ind   = wr_go & at_lo & ~is_fifo;
    wire wr_split = wr_go & at_lo & is_fifo & ~bhe_s;

    iirp_byte_t ind_rd;
    always_comb begin
        case (index_q)
            `IIRP_IX_CHIPCTL:  ind_rd = chipctl_q;
            `IIRP_IX_IRQEN:    ind_rd = irqen_q;
            `IIRP_IX_IRQSTAT:  ind_rd = status;
            `IIRP_IX_RATE_LO:  ind_rd = rate_lo_q;
            `IIRP_IX_RATE_HI:  ind_rd = {4'h0, rate_hi_q};
            `IIRP_IX_RATE_CTL: ind_rd = ratectl_q;
            default:           ind_rd = 8'h00; // pairsel and reserved read zero
        endcase
    end

    logic [15:0] rd_mux;
    always_comb begin
        case (addr_s)
            `IIRP_OFS_STATUS: rd_mux = paired ? 16'h0 : {8'h00, status};
            `IIRP_OFS_INDEX:  rd_mux = paired ? 16'h0 : {8'h00, index_q};
            `IIRP_OFS_DLOW:   rd_mux = is_fifo ? (bhe_s ? fifo_mem[rp_q[`IIRP_FIFO_AW-1:0]]
                                       : {8'h00, fifo_mem[rp_q[`IIRP_FIFO_AW-1:0]][7:0]})
                                       : {8'h00, ind_rd};
            default:          rd_mux = is_fifo ? {8'h00, fifo_mem[rp_q[`IIRP_FIFO_AW-1:0]][15:8]} : 16'h0;
        endcase
    end

    wire pop_host = rd_go & is_fifo & ~fifo_empty & ((at_lo & bhe_s) | at_hi);
    wire pop = (pop_host | play_fifo_pop) & ~fifo_empty;

    // strobe history, pin enable and the registered irq pin
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rd_p_q <= 1'b0;
            wr_p_q <= 1'b0;
            irq_q  <= 1'b0;
            oe_n_q <= 1'b1;
        end else begin
            rd_p_q <= rd_s;
            wr_p_q <= wr_s;
            irq_q  <= irq_d;
            oe_n_q <= ~(rd_s & cs_s);
        end
    end

    // sticky sources; a new event wins over a clear in the same cycle
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pending_q <= 8'h00;
            clear_q   <= 8'h00;
        end else begin
            pending_q[5:0] <= (pending_q[5:0] & ~clear_q[5:0]) | irq_events;
            if (wr_clear) begin
                clear_q <= {2'b00, wd_s[5:0]};
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            index_q <= 8'h00;
        end else if (wr_index) begin
            index_q <= wd_s[7:0];
        end
    end

    // byte-wide indirect registers, rate high only 4 bits; unknown indices swallow the write
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pairsel_q <= 8'h00;
            chipctl_q <= 8'h00;
            irqen_q   <= 8'h00;
            rate_lo_q <= 8'h00;
            rate_hi_q <= 4'h0;
            ratectl_q <= 8'h00;
        end else if (wr_ind) begin
            case (index_q)
                `IIRP_IX_PAIRSEL:  pairsel_q <= wd_s[7:0];
                `IIRP_IX_CHIPCTL:  chipctl_q <= wd_s[7:0];
                `IIRP_IX_IRQEN:    irqen_q <= wd_s[7:0];
                `IIRP_IX_RATE_LO:  rate_lo_q <= wd_s[7:0];
                `IIRP_IX_RATE_HI:  rate_hi_q <= wd_s[3:0];
                `IIRP_IX_RATE_CTL: ratectl_q <= wd_s[7:0];
                default:           ;
            endcase
        end
    end

    // low half of a split word waits here for the high port write
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            split_lo_q <= 8'h00;
        end else if (wr_split) begin
            split_lo_q <= wd_s[7:0];
        end
    end

    // read data stands until the next selected read
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            bus.dev_data <= 16'h0;
        end else if (rd_go) begin
            bus.dev_data <= rd_mux;
        end
    end

    // pointers only; a push into a full fifo is dropped, not queued
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end

    // storage has no reset, so it stays out of the reset process
    always_ff @(posedge clock) begin
        if (push) begin
            fifo_mem[wp_q[`IIRP_FIFO_AW-1:0]] <= push_word;
        end
    end

    assign bus.irq = irq_q;
    assign bus.dev_data_oe_n = oe_n_q;
    assign play_fifo_full = fifo_full;
    assign play_fifo_empty = fifo_empty;
    assign play_fifo_head = fifo_mem[rp_q[`IIRP_FIFO_AW-1:0]];
    assign chip_control = chipctl_q;
    assign sample_rate = {rate_hi_q, rate_lo_q};
    assign rate_control = ratectl_q;
endmodule // iirp_device
`default_nettype wire

// ==== iirp_host.sv ====
`include "iirp_defs.svh"
`default_nettype none
// host end: software port drives indexed accesses onto the io bus
module iirp_host (
    input  wire logic              clock,
    input  wire logic              nrst,
    iirp_bus_if.host               bus,
    input  wire logic [1:0]        sw_addr,
    input  wire logic [15:0]       sw_wdata,
    input  wire logic              sw_write,
    input  wire logic              sw_read,
    output logic      [15:0]       sw_rdata,
    output logic                   irq_level
);
    import iirp_pkg::*;

    iirp_state_t st_q;
    logic [7:0]  ix_q;
    logic [15:0] wdat_q, res_q, rdata_q;
    logic [3:0]  ctl_q;
    logic [3:0]  ph_q;
    logic        busy_q;
    logic        dir_q;
    logic        irq_s;
    logic [15:0] din_s;

    iirp_pin_sync #(.W(17)) u_sync (
        .clock (clock),
        .nrst  (nrst),
        .pin   ({bus.irq, bus.dev_data}),
        .level ({irq_s, din_s})
    );

    // each bus phase lasts 16 cycles so device synchronisers settle
    wire ph_end = ph_q == `IIRP_PH_LAST;
    wire cs_on  = ph_q < `IIRP_PH_CS_OFF;
    wire stb_on = ph_q > `IIRP_PH_STB_ON && ph_q < `IIRP_PH_STB_OFF;
    // device answers about 5 clocks into the strobe, the return sync adds 4 more
    wire sample = ph_q == `IIRP_PH_SAMPLE;
    wire rd_op  = ctl_q[`IIRP_CTL_READ];
    wire wide   = ctl_q[`IIRP_CTL_WIDE];
    wire split  = ctl_q[`IIRP_CTL_SPLIT];

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_q <= IIRP_IDLE;
            ix_q <= 8'h00;
            wdat_q <= 16'h0;
            res_q <= 16'h0;
            ctl_q <= 4'h0;
            ph_q <= 4'h0;
            busy_q <= 1'b0;
            dir_q <= 1'b0;
            rdata_q <= 16'h0;
            bus.cs_n <= 1'b1;
            bus.ior_n <= 1'b1;
            bus.iow_n <= 1'b1;
            bus.sbhe_n <= 1'b1;
            bus.addr <= 2'h0;
            bus.host_data <= 16'h0;
        end else begin
            ph_q <= (st_q == IIRP_IDLE) ? 4'h0 : ph_q + 4'h1;
            if (sw_read) begin
                case (sw_addr)
                    `IIRP_SW_ADDR:   rdata_q <= {8'h00, ix_q};
                    `IIRP_SW_WDATA:  rdata_q <= wdat_q;
                    `IIRP_SW_CTRL:   rdata_q <= {10'h0, dir_q, busy_q, ctl_q};
                    default:         rdata_q <= res_q;
                endcase
            end
            if (sw_write && st_q == IIRP_IDLE) begin
                case (sw_addr)
                    `IIRP_SW_ADDR:  ix_q <= sw_wdata[7:0];
                    `IIRP_SW_WDATA: wdat_q <= sw_wdata;
                    `IIRP_SW_CTRL: begin
                        ctl_q <= sw_wdata[3:0];
                        dir_q <= sw_wdata[`IIRP_CTL_DIRECT];
                        if (sw_wdata[`IIRP_CTL_START]) begin
                            busy_q <= 1'b1;
                            // a direct access skips the pointer write
                            st_q <= sw_wdata[`IIRP_CTL_DIRECT] ? IIRP_DLOW : IIRP_SETIX;
                        end
                    end
                    default: ;
                endcase
            end
            case (st_q)
                IIRP_IDLE: ;
                IIRP_SETIX: begin
                    bus.cs_n <= ~cs_on;
                    bus.addr <= `IIRP_OFS_INDEX;
                    bus.host_data <= {8'h00, ix_q};
                    bus.iow_n <= ~stb_on;
                    if (ph_end) st_q <= IIRP_DLOW;
                end
                IIRP_DLOW: begin
                    bus.cs_n <= ~cs_on;
                    // direct mode uses the index field as the bus offset
                    bus.addr <= dir_q ? ix_q[1:0] : `IIRP_OFS_DLOW;
                    bus.sbhe_n <= ~wide;
                    bus.host_data <= wdat_q;
                    bus.iow_n <= ~(~rd_op && stb_on);
                    bus.ior_n <= ~(rd_op && stb_on);
                    if (rd_op && sample) res_q <= wide ? din_s : {8'h00, din_s[7:0]};
                    if (ph_end) st_q <= split ? IIRP_DHIGH : IIRP_DONE;
                end
                IIRP_DHIGH: begin
                    bus.cs_n <= ~cs_on;
                    bus.addr <= `IIRP_OFS_DHIGH;
                    bus.sbhe_n <= 1'b1;
                    bus.host_data <= {8'h00, wdat_q[15:8]};
                    bus.iow_n <= ~(~rd_op && stb_on);
                    bus.ior_n <= ~(rd_op && stb_on);
                    if (rd_op && sample) res_q[15:8] <= din_s[7:0];
                    if (ph_end) st_q <= IIRP_DONE;
                end
                IIRP_DONE: begin
                    busy_q <= 1'b0;
                    bus.cs_n <= 1'b1;
                    bus.sbhe_n <= 1'b1;
                    st_q <= IIRP_IDLE;
                end
                default: st_q <= IIRP_IDLE;
            endcase
        end
    end

    assign sw_rdata = rdata_q;
    assign irq_level = irq_s;
endmodule // iirp_host
`default_nettype wire

// ==== iirp_bus_monitor.sv ====
`default_nettype none
module iirp_bus_monitor (
    input wire logic        clock,
    input wire logic        nrst,
    input wire logic        cs_n,
    input wire logic        ior_n,
    input wire logic        iow_n,
    input wire logic        sbhe_n,
    input wire logic [1:0]  addr,
    input wire logic [15:0] host_data,
    input wire logic        dev_data_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    wire strobe = !ior_n || !iow_n;

    a_drive_when_sel: assert property ($fell(dev_data_oe_n) |-> !cs_n && !ior_n)
        else $error("device drove data outside a selected read");
    a_drive_release: assert property ($rose(ior_n) |-> ##[0:8] dev_data_oe_n)
        else $error("device kept driving after the read ended");
    a_read_answer: assert property (($fell(ior_n) && !cs_n) |-> ##[1:8] !dev_data_oe_n)
        else $error("selected read not answered");
    a_sel_frames: assert property (strobe |-> !cs_n)
        else $error("strobe without device select");
    a_strobe_excl: assert property (!(!ior_n && !iow_n))
        else $error("read and write strobes together");
    a_word_low: assert property ((strobe && !sbhe_n) |-> addr == 2'h2)
        else $error("word access away from the low data port");
    a_high_byte: assert property ((strobe && addr == 2'h3) |-> sbhe_n)
        else $error("high data port accessed as a word");
    a_write_hold: assert property ((!iow_n && !$past(iow_n)) |-> $stable(addr) && $stable(host_data))
        else $error("address or data moved during a write");
    a_write_len: assert property ($fell(iow_n) |-> !iow_n [*8])
        else $error("write strobe too short");
endmodule // iirp_bus_monitor
`default_nettype wire

// ==== isa_indirect_register_port_test.sv ====
`default_nettype none
module isa_indirect_register_port_test;
    timeunit 1ns;
    timeprecision 100ps;
    import iirp_pkg::*;
    logic clock, nrst, sw_write, sw_read, play_fifo_pop;
    logic [1:0] sw_addr;
    logic [15:0] sw_wdata;
    logic [5:0] irq_events;
    wire logic [15:0] sw_rdata;
    wire logic irq_level, play_fifo_full, play_fifo_empty;
    iirp_word_t play_fifo_head;
    iirp_byte_t chip_control, rate_control;
    logic [11:0] sample_rate;
    logic dmode;
    int err_total = 0, checks_done = 0, cycles = 0;

    iirp_bus_if bus_if ();
    iirp_host iirp_host_i (.clock(clock), .nrst(nrst), .bus(bus_if), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
        .sw_write(sw_write), .sw_read(sw_read), .sw_rdata(sw_rdata), .irq_level(irq_level));
    iirp_device iirp_device_i (.clock(clock), .nrst(nrst), .bus(bus_if), .irq_events(irq_events),
        .play_fifo_pop(play_fifo_pop), .play_fifo_full(play_fifo_full), .play_fifo_head(play_fifo_head),
        .play_fifo_empty(play_fifo_empty), .chip_control(chip_control), .sample_rate(sample_rate),
        .rate_control(rate_control));
    iirp_bus_monitor iirp_bus_monitor_i (.clock(clock), .nrst(nrst), .cs_n(bus_if.cs_n), .ior_n(bus_if.ior_n),
        .iow_n(bus_if.iow_n), .sbhe_n(bus_if.sbhe_n), .addr(bus_if.addr), .host_data(bus_if.host_data),
        .dev_data_oe_n(bus_if.dev_data_oe_n));

    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    task results;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // whole run needs a few thousand cycles
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_total++;
            results();
        end
    end

    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task sw_wr(input logic [1:0] a, input logic [15:0] d);
        @(posedge clock);
        sw_addr <= a;
        sw_wdata <= d;
        sw_write <= 1'b1;
        @(posedge clock);
        sw_write <= 1'b0;
    endtask

    task sw_rd(input logic [1:0] a, output logic [15:0] d);
        @(posedge clock);
        sw_addr <= a;
        sw_read <= 1'b1;
        @(posedge clock);
        sw_read <= 1'b0;
        @(posedge clock);
        d = sw_rdata;
    endtask

    // ctl: bit0 start, bit1 read, bit2 word, bit3 split; dmode sets bit5 direct
    task op(input logic [7:0] ix, input logic [15:0] d, input logic [3:0] ctl);
        logic [15:0] r;
        int n;
        sw_wr(2'h0, {8'h00, ix});
        sw_wr(2'h1, d);
        sw_wr(2'h2, {10'h000, dmode, 1'b0, ctl});
        repeat (2) @(posedge clock);
        n = 0;
        do begin
            sw_rd(2'h2, r);
            n++;
        end while (r[4] !== 1'b0 && n < 300);
        if (n >= 300) begin
            err_total++;
            $display("BAD busy stuck at index %h", ix);
        end
    endtask

    task rdix(input logic [7:0] ix, output logic [7:0] v);
        logic [15:0] r;
        op(ix, 16'h0000, 4'h3);
        sw_rd(2'h3, r);
        v = r[7:0];
    endtask

    // direct access to a bus offset, no pointer write
    task dacc(input logic [1:0] ofs, input logic [15:0] d, input logic rd, output logic [7:0] v);
        logic [15:0] r;
        dmode = 1'b1;
        op({6'h00, ofs}, d, {2'b00, rd, 1'b1});
        dmode = 1'b0;
        sw_rd(2'h3, r);
        v = r[7:0];
    endtask

    task pop;
        @(posedge clock);
        play_fifo_pop <= 1'b1;
        @(posedge clock);
        play_fifo_pop <= 1'b0;
        repeat (2) @(posedge clock);
    endtask

    task t_regs;
        logic [7:0] v;
        op(8'h80, 16'h005A, 4'h1);
        chk("chip_control", {8'h00, chip_control}, 16'h005A);
        op(8'h84, 16'h0034, 4'h1);
        op(8'h85, 16'h000C, 4'h1);
        chk("sample_rate", {4'h0, sample_rate}, 16'h0C34);
        op(8'h86, 16'h0081, 4'h1);
        chk("rate_control", {8'h00, rate_control}, 16'h0081);
        rdix(8'h80, v);
        chk("chip_control readback", {8'h00, v}, 16'h005A);
    endtask

    task t_fifo;
        logic [7:0] v;
        op(8'h0B, 16'hA55A, 4'h5);
        chk("word head", play_fifo_head, 16'hA55A);
        pop();
        op(8'h0B, 16'h1234, 4'h9);
        chk("split head", play_fifo_head, 16'h1234);
        pop();
        chk("fifo empty", {15'h0000, play_fifo_empty}, 16'h0001);
        rdix(8'h83, v);
        chk("busy not full", {15'h0000, v[6]}, 16'h0001);
        for (int i = 0; i < 16; i++) op(8'h0B, 16'h0100 + i[15:0], 4'h5);
        chk("fifo full", {15'h0000, play_fifo_full}, 16'h0001);
        rdix(8'h83, v);
        chk("busy full", {15'h0000, v[6]}, 16'h0000);
        for (int i = 0; i < 16; i++) begin
            chk("drain order", play_fifo_head, 16'h0100 + i[15:0]);
            pop();
        end
        chk("drained", {15'h0000, play_fifo_empty}, 16'h0001);
    endtask

    task t_irq;
        logic [7:0] v;
        @(posedge clock);
        irq_events <= 6'h01;
        @(posedge clock);
        irq_events <= 6'h00;
        op(8'h81, 16'h0081, 4'h1);
        repeat (12) @(posedge clock);
        chk("irq raised", {15'h0000, irq_level}, 16'h0001);
        rdix(8'h83, v);
        chk("status enabled", {8'h00, v}, 16'h00C1);
        op(8'h81, 16'h0001, 4'h1);
        repeat (12) @(posedge clock);
        chk("irq masked", {15'h0000, irq_level}, 16'h0000);
        rdix(8'h83, v);
        chk("status masked", {8'h00, v}, 16'h0041);
    endtask

    task t_direct;
        logic [7:0] v;
        dacc(2'h1, 16'h0000, 1'b1, v);
        chk("pointer readback", {8'h00, v}, 16'h0083);
        op(8'h81, 16'h0081, 4'h1);
        dacc(2'h0, 16'h0001, 1'b0, v);
        chk("irq held off", {15'h0000, irq_level}, 16'h0000);
        dacc(2'h0, 16'h0000, 1'b1, v);
        chk("status cleared", {8'h00, v}, 16'h0040);
        irq_events <= 6'h01;
        repeat (12) @(posedge clock);
        chk("irq still held", {15'h0000, irq_level}, 16'h0000);
        dacc(2'h0, 16'h0000, 1'b0, v);
        repeat (12) @(posedge clock);
        chk("irq fresh edge", {15'h0000, irq_level}, 16'h0001);
        irq_events <= 6'h00;
        dacc(2'h0, 16'h0000, 1'b1, v);
        chk("status direct", {8'h00, v}, 16'h00C1);
        op(8'h81, 16'h0001, 4'h1);
    endtask

    task t_paired;
        logic [7:0] v;
        op(8'h4E, 16'h0001, 4'h1);
        dacc(2'h0, 16'h0000, 1'b1, v);
        chk("direct status hidden", {8'h00, v}, 16'h0000);
        dacc(2'h1, 16'h0000, 1'b1, v);
        chk("pointer hidden", {8'h00, v}, 16'h0000);
        rdix(8'h4E, v);
        chk("select hidden", {8'h00, v}, 16'h0000);
        rdix(8'h83, v);
        chk("paired status", {8'h00, v}, 16'h0041);
    endtask

    initial begin
        nrst = 1'b0;
        sw_write = 1'b0;
        sw_read = 1'b0;
        sw_addr = 2'h0;
        sw_wdata = 16'h0000;
        irq_events = 6'h00;
        play_fifo_pop = 1'b0;
        dmode = 1'b0;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        @(posedge clock);
        t_regs();
        t_fifo();
        t_irq();
        t_direct();
        t_paired();
        results();
    end
endmodule // isa_indirect_register_port_test
`default_nettype wire
